// file: rtl/monitor_interrupt_control.sv
// Configuration, event status and interrupt masking of the hardware monitor
// Behaviour
// - Config bit 0 starts monitoring, clear is standby
// - Clearing start keeps raised interrupt outputs asserted
// - Config bit 1 enables management interrupt output
// - Config bit 2 enables the NMI/IRQ output
// - Hold-off silences both interrupt outputs, freezes both status registers
// - Hold-off suspends monitoring until software clears it
// - Reset request bit drives 20 ms low pulse
// - Reset request clears itself when pulse ends
// - Config bit 5 selects NMI or active-low IRQ
// - Config bit 6 pulls power bypass pin low
// - Init bit restores defaults, then reads zero
// - Configuration powers up as 0x08, hold-off set
// - Limit flags latch channel and temperature excursions
// - Board temperature alert sets status 1 bit 5
// - Fan limit flags: bits 6, 7 and status 2 bit 3
// - Intrusion rising sets status 2 bit 4
// - Thirty-second POST write sets overflow flag
// - Low chained input sets status 2 bit 6
// - Status and management masks reset to zero; status is read-only
// - Management mask bit excludes its status flag
// - Mask 2 bit 7 enables reset pulse generation
// - NMI masks exclude flags; chained mask resets one
// - Pointer auto-increments across paired registers
module monitor_interrupt_control
  import monitor_irq_pkg::*;
#(
  parameter int unsigned RESET_PULSE_CYCLES = monitor_irq_pkg::RESET_PULSE_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire monitor_irq_pkg::host_req_t host_req,
  output logic [monitor_irq_pkg::DATA_W-1:0] host_rdata,
  input wire monitor_irq_pkg::monitor_events_t events,
  output logic system_mgmt_irq_n,
  output logic alt_irq,
  output logic reset_out_n,
  input wire logic power_bypass_in,
  output logic power_bypass_out,
  output logic power_bypass_oe_n
);
  import monitor_irq_pkg::*;

  localparam logic [RST_CNT_W-1:0] PULSE_LOAD = RST_CNT_W'(RESET_PULSE_CYCLES - 1);

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic monitoring;
  logic hold;
  logic data_wr;
  logic data_rd;
  logic [DATA_W-1:0] set_lo;
  logic [DATA_W-1:0] set_hi;
  logic smi_pend;
  logic alt_pend;
  logic alt_active;
  logic overflow_hit;
  logic [DATA_W-1:0] rd_mux;

  assign hold = st.cfg[CFG_HOLD];
  assign monitoring = st.cfg[CFG_START] && !hold;
  assign data_wr = host_req.wr && host_req.data_port;
  assign data_rd = host_req.rd && host_req.data_port;
  assign overflow_hit = events.post_write && (st.post_cnt == POST_LAST);

  // Comparator and fan results only count while the monitor runs
  always_comb begin
    set_lo = ZERO_BYTE;
    set_hi = ZERO_BYTE;
    if (monitoring) begin
      set_lo[ST1_TEMP-1:0] = events.analog_limit[ST1_TEMP-1:0];
      set_lo[ST1_TEMP] = events.temp_limit;
      set_lo[ST1_BOARD] = !events.board_temp_alert_n;
      set_lo[ST1_TACH1] = events.tach_limit[0];
      set_lo[ST1_TACH2] = events.tach_limit[1];
      set_hi[0] = events.analog_limit[ST1_TEMP];
      set_hi[2:1] = events.negative_limit;
      set_hi[ST2_TACH3] = events.tach_limit[2];
    end
    set_hi[ST2_INTRUSION] = events.intrusion && !st.intrusion_d;
    set_hi[ST2_OVERFLOW] = overflow_hit;
    set_hi[ST2_CHAINED] = !events.chained_irq_input_n;
    set_hi[ST2_RESERVED] = 1'b0;
  end

  assign smi_pend = |(st.stat_lo & ~st.smask_lo) ||
                    |(st.stat_hi[ST2_CHAINED:0] & ~st.smask_hi[ST2_CHAINED:0]);
  assign alt_pend = |(st.stat_lo & ~st.nmask_lo) ||
                    |(st.stat_hi[ST2_CHAINED:0] & ~st.nmask_hi[ST2_CHAINED:0]);
  assign alt_active = st.cfg[CFG_ALT_EN] && !hold && alt_pend;

  always_comb begin
    case (st.ptr)
      ADDR_CFG: rd_mux = st.cfg;
      ADDR_STAT_LO: rd_mux = st.stat_lo;
      ADDR_STAT_HI: rd_mux = st.stat_hi;
      ADDR_SMASK_LO: rd_mux = st.smask_lo;
      ADDR_SMASK_HI: rd_mux = st.smask_hi;
      ADDR_NMASK_LO: rd_mux = st.nmask_lo;
      ADDR_NMASK_HI: rd_mux = st.nmask_hi;
      default: rd_mux = ZERO_BYTE;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.intrusion_d = events.intrusion;

    // Reset pulse runs first so that a host write in the same cycle wins
    case (st.rst_st)
      RST_IDLE: begin
        if (st.cfg[CFG_RST_REQ] && st.smask_hi[SMASK2_RST_EN]) begin
          next_st.rst_st = RST_PULSE;
          next_st.rst_cnt = PULSE_LOAD;
          next_st.reset_out_n = 1'b0;
        end
      end
      RST_PULSE: begin
        if (st.rst_cnt == '0) begin
          next_st.rst_st = RST_IDLE;
          next_st.reset_out_n = 1'b1;
          next_st.cfg[CFG_RST_REQ] = 1'b0;
        end else begin
          next_st.rst_cnt = st.rst_cnt - 1'b1;
        end
      end
      default: begin
        next_st.rst_st = RST_IDLE;
        next_st.reset_out_n = 1'b1;
      end
    endcase

    if (host_req.wr && !host_req.data_port) begin
      next_st.ptr = host_req.wdata[ADDR_W-1:0];
    end
    if (host_req.rd && !host_req.data_port) begin
      next_st.rdata = {1'b0, st.ptr};
    end

    if (data_wr) begin
      case (st.ptr)
        ADDR_CFG: next_st.cfg = host_req.wdata;
        ADDR_SMASK_LO: next_st.smask_lo = host_req.wdata;
        ADDR_SMASK_HI: next_st.smask_hi = host_req.wdata;
        ADDR_NMASK_LO: next_st.nmask_lo = host_req.wdata;
        ADDR_NMASK_HI: next_st.nmask_hi = host_req.wdata;
        default: ;
      endcase
    end

    // Reading a status register clears it, except under hold-off
    if (data_rd) begin
      next_st.rdata = rd_mux;
      if (!hold && st.ptr == ADDR_STAT_LO) begin
        next_st.stat_lo = STAT_RESET;
      end
      if (!hold && st.ptr == ADDR_STAT_HI) begin
        next_st.stat_hi = STAT_RESET;
      end
    end

    if (data_wr || data_rd) begin
      if (st.ptr == ADDR_STAT_LO || st.ptr == ADDR_SMASK_LO || st.ptr == ADDR_NMASK_LO) begin
        next_st.ptr = st.ptr + 1'b1;
      end
    end

    // A set in the same cycle as a read clear is kept
    if (!hold) begin
      next_st.stat_lo = next_st.stat_lo | set_lo;
      next_st.stat_hi = next_st.stat_hi | set_hi;
    end

    if (events.post_write && st.post_cnt != POST_LAST) begin
      next_st.post_cnt = st.post_cnt + 1'b1;
    end

    // Outputs look at the present flags, not at start, so standby keeps them
    next_st.smi_n = !(st.cfg[CFG_SMI_EN] && !hold && smi_pend);
    next_st.alt_irq = st.cfg[CFG_ALT_SEL] ? alt_active : !alt_active;

    // Init keeps the pointer and a running reset pulse
    if (data_wr && st.ptr == ADDR_CFG && host_req.wdata[CFG_INIT]) begin
      next_st.cfg = CFG_RESET;
      next_st.stat_lo = STAT_RESET;
      next_st.stat_hi = STAT_RESET;
      next_st.smask_lo = SMASK_RESET;
      next_st.smask_hi = SMASK_RESET;
      next_st.nmask_lo = NMASK_LO_RESET;
      next_st.nmask_hi = NMASK_HI_RESET;
      next_st.post_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign host_rdata = st.rdata;
  assign system_mgmt_irq_n = st.smi_n;
  assign alt_irq = st.alt_irq;
  assign reset_out_n = st.reset_out_n;
  // Open drain: only ever drives low
  assign power_bypass_out = 1'b0;
  assign power_bypass_oe_n = !st.cfg[CFG_BYPASS];

  // Helper for the pulse length check
  int unsigned low_len;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      low_len <= 0;
    end else if (!reset_out_n) begin
      low_len <= low_len + 1;
    end else begin
      low_len <= 0;
    end
  end

  logic cfg_wr;
  assign cfg_wr = data_wr && st.ptr == ADDR_CFG;

  property p_smi_off;
    @(posedge sys_clk) disable iff (!rstn)
      !st.cfg[CFG_SMI_EN] |=> system_mgmt_irq_n;
  endproperty
  a_smi_off: assert property (p_smi_off)
    else $error("management interrupt asserted while disabled");

  property p_alt_off;
    @(posedge sys_clk) disable iff (!rstn)
      !st.cfg[CFG_ALT_EN] |=> alt_irq == !$past(st.cfg[CFG_ALT_SEL]);
  endproperty
  a_alt_off: assert property (p_alt_off)
    else $error("NMI/IRQ output active while disabled");

  property p_hold;
    @(posedge sys_clk) disable iff (!rstn)
      (hold && !cfg_wr) |=> $stable(st.stat_lo) && $stable(st.stat_hi) &&
        system_mgmt_irq_n && alt_irq == !$past(st.cfg[CFG_ALT_SEL]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold-off did not freeze status or silence outputs");

  property p_rst_len;
    @(posedge sys_clk) disable iff (!rstn)
      $rose(reset_out_n) |-> low_len == RESET_PULSE_CYCLES && !st.cfg[CFG_RST_REQ] || $past(cfg_wr);
  endproperty
  a_rst_len: assert property (p_rst_len)
    else $error("reset pulse length wrong or request not cleared");

  property p_rst_gate;
    @(posedge sys_clk) disable iff (!rstn)
      (reset_out_n && !st.smask_hi[SMASK2_RST_EN]) |=> reset_out_n;
  endproperty
  a_rst_gate: assert property (p_rst_gate)
    else $error("reset pulse started without reset enable");

  property p_bypass;
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_wr && !host_req.wdata[CFG_INIT]) |=>
        power_bypass_oe_n == !$past(host_req.wdata[CFG_BYPASS]);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("power bypass pin does not follow its bit");

  property p_init;
    @(posedge sys_clk) disable iff (!rstn)
      (cfg_wr && host_req.wdata[CFG_INIT]) |=> st.cfg == CFG_RESET &&
        st.stat_lo == STAT_RESET && st.nmask_hi == NMASK_HI_RESET;
  endproperty
  a_init: assert property (p_init)
    else $error("init did not restore defaults");

  property p_intrusion;
    @(posedge sys_clk) disable iff (!rstn)
      (!hold && events.intrusion && !st.intrusion_d && !cfg_wr) |=> st.stat_hi[ST2_INTRUSION];
  endproperty
  a_intrusion: assert property (p_intrusion)
    else $error("intrusion edge not latched");

  property p_chained;
    @(posedge sys_clk) disable iff (!rstn)
      (!hold && !events.chained_irq_input_n && !cfg_wr) |=> st.stat_hi[ST2_CHAINED];
  endproperty
  a_chained: assert property (p_chained)
    else $error("chained interrupt not latched");

  property p_autoinc;
    @(posedge sys_clk) disable iff (!rstn)
      ((data_wr || data_rd) && st.ptr == ADDR_STAT_LO && !host_req.wr) |=> st.ptr == ADDR_STAT_HI;
  endproperty
  a_autoinc: assert property (p_autoinc)
    else $error("pointer did not advance to status 2");

  property p_masked;
    @(posedge sys_clk) disable iff (!rstn)
      (&st.smask_lo && &st.smask_hi[ST2_CHAINED:0]) |=> system_mgmt_irq_n;
  endproperty
  a_masked: assert property (p_masked)
    else $error("fully masked flags raised management interrupt");

  property p_smi_on;
    @(posedge sys_clk) disable iff (!rstn)
      (st.cfg[CFG_SMI_EN] && !hold && st.stat_lo[ST1_TEMP] && !st.smask_lo[ST1_TEMP]) |=>
        !system_mgmt_irq_n;
  endproperty
  a_smi_on: assert property (p_smi_on)
    else $error("unmasked flag did not raise management interrupt");

  property p_alt_on;
    @(posedge sys_clk) disable iff (!rstn)
      (st.cfg[CFG_ALT_EN] && !hold && st.stat_lo[ST1_TEMP] && !st.nmask_lo[ST1_TEMP]) |=>
        alt_irq == $past(st.cfg[CFG_ALT_SEL]);
  endproperty
  a_alt_on: assert property (p_alt_on)
    else $error("unmasked flag did not raise NMI/IRQ output");

  property p_standby;
    @(posedge sys_clk) disable iff (!rstn)
      (!st.cfg[CFG_START] && !st.stat_lo[ST1_TEMP]) |=> !st.stat_lo[ST1_TEMP];
  endproperty
  a_standby: assert property (p_standby)
    else $error("limit flag latched in standby");

  property p_overflow;
    @(posedge sys_clk) disable iff (!rstn)
      (overflow_hit && !hold && !cfg_wr) |=> st.stat_hi[ST2_OVERFLOW];
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("POST overflow not latched");

  // The pin loops back through the outside pull-up, so a low drive must read low
  property p_bypass_pin;
    @(posedge sys_clk) disable iff (!rstn)
      !power_bypass_oe_n |-> !power_bypass_in;
  endproperty
  a_bypass_pin: assert property (p_bypass_pin)
    else $error("power bypass pin not pulled low");

  c_smi: cover property (@(posedge sys_clk) disable iff (!rstn) $fell(system_mgmt_irq_n));
  c_alt_nmi: cover property (@(posedge sys_clk) disable iff (!rstn)
    st.cfg[CFG_ALT_SEL] && $rose(alt_irq));
  c_reset: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(reset_out_n));
  c_overflow: cover property (@(posedge sys_clk) disable iff (!rstn) overflow_hit);

endmodule

// file: rtl/monitor_irq_pkg.sv
// Constants, carriers and state types of the monitor interrupt control block
package monitor_irq_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_CFG = 7'h40;
  localparam logic [ADDR_W-1:0] ADDR_STAT_LO = 7'h41;
  localparam logic [ADDR_W-1:0] ADDR_STAT_HI = 7'h42;
  localparam logic [ADDR_W-1:0] ADDR_SMASK_LO = 7'h43;
  localparam logic [ADDR_W-1:0] ADDR_SMASK_HI = 7'h44;
  localparam logic [ADDR_W-1:0] ADDR_NMASK_LO = 7'h45;
  localparam logic [ADDR_W-1:0] ADDR_NMASK_HI = 7'h46;

  localparam int CFG_START = 0;
  localparam int CFG_SMI_EN = 1;
  localparam int CFG_ALT_EN = 2;
  localparam int CFG_HOLD = 3;
  localparam int CFG_RST_REQ = 4;
  localparam int CFG_ALT_SEL = 5;
  localparam int CFG_BYPASS = 6;
  localparam int CFG_INIT = 7;

  localparam int ST1_TEMP = 4;
  localparam int ST1_BOARD = 5;
  localparam int ST1_TACH1 = 6;
  localparam int ST1_TACH2 = 7;
  localparam int ST2_TACH3 = 3;
  localparam int ST2_INTRUSION = 4;
  localparam int ST2_OVERFLOW = 5;
  localparam int ST2_CHAINED = 6;
  localparam int ST2_RESERVED = 7;
  localparam int SMASK2_RST_EN = 7;

  localparam logic [DATA_W-1:0] CFG_RESET = 8'h08;
  localparam logic [DATA_W-1:0] STAT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] SMASK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] NMASK_LO_RESET = 8'h00;
  localparam logic [DATA_W-1:0] NMASK_HI_RESET = 8'h40;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_RESET = 7'h00;

  localparam int POST_CNT_W = 5;
  localparam logic [POST_CNT_W-1:0] POST_LAST = 5'h1f;

  localparam int RESET_PULSE_MS = 20;
  localparam int CLK_MHZ = 250;
  localparam int RESET_PULSE_DEFAULT = RESET_PULSE_MS * 1000 * CLK_MHZ;
  localparam int RST_CNT_W = 23;

  // Host port: address port (data_port = 0) or data port (data_port = 1)
  typedef struct packed {
    logic wr;
    logic rd;
    logic data_port;
    logic [DATA_W-1:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [4:0] analog_limit;
    logic [1:0] negative_limit;
    logic temp_limit;
    logic [2:0] tach_limit;
    logic board_temp_alert_n;
    logic intrusion;
    logic chained_irq_input_n;
    logic post_write;
  } monitor_events_t;

  typedef enum logic {RST_IDLE, RST_PULSE} rst_state_t;

  typedef struct packed {
    logic [DATA_W-1:0] cfg;
    logic [DATA_W-1:0] stat_lo;
    logic [DATA_W-1:0] stat_hi;
    logic [DATA_W-1:0] smask_lo;
    logic [DATA_W-1:0] smask_hi;
    logic [DATA_W-1:0] nmask_lo;
    logic [DATA_W-1:0] nmask_hi;
    logic [ADDR_W-1:0] ptr;
    logic [POST_CNT_W-1:0] post_cnt;
    logic intrusion_d;
    rst_state_t rst_st;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic reset_out_n;
    logic smi_n;
    logic alt_irq;
    logic [DATA_W-1:0] rdata;
  } ctrl_state_t;

  localparam ctrl_state_t ST_RESET = '{
    cfg: CFG_RESET, stat_lo: STAT_RESET, stat_hi: STAT_RESET,
    smask_lo: SMASK_RESET, smask_hi: SMASK_RESET,
    nmask_lo: NMASK_LO_RESET, nmask_hi: NMASK_HI_RESET,
    ptr: PTR_RESET, post_cnt: '0, intrusion_d: 1'b0, rst_st: RST_IDLE,
    rst_cnt: '0, reset_out_n: 1'b1, smi_n: 1'b1, alt_irq: 1'b1, rdata: ZERO_BYTE};

endpackage

// file: dv/host_port_model.sv
// Host software model that reaches the monitor registers through its address and data ports
module host_port_model (
  input wire logic sys_clk,
  input wire logic [monitor_irq_pkg::DATA_W-1:0] host_rdata,
  output monitor_irq_pkg::host_req_t host_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import monitor_irq_pkg::*;

  initial host_req = '{wr: 1'b0, rd: 1'b0, data_port: 1'b0, wdata: 8'h00};

  // Idle data is inverted so nothing can lean on a stale byte
  task automatic access(input logic w, input logic dp, input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    host_req = '{wr: w, rd: !w, data_port: dp, wdata: d};
    @(negedge sys_clk);
    host_req = '{wr: 1'b0, rd: 1'b0, data_port: dp, wdata: ~d};
  endtask

  task automatic set_ptr(input logic [ADDR_W-1:0] a);
    access(1'b1, 1'b0, {1'b0, a});
  endtask

  task automatic get(output logic [DATA_W-1:0] d);
    access(1'b0, 1'b1, 8'h00);
    d = host_rdata;
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    set_ptr(a);
    access(1'b1, 1'b1, d);
  endtask

  // Monitoring only starts once hold-off is dropped and start is set
  task automatic start_monitor(input logic [DATA_W-1:0] en);
    wr_reg(ADDR_CFG, (en & 8'hf7) | 8'h01);
  endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the monitor interrupt control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import monitor_irq_pkg::*;

  localparam int PULSE = 16;
  localparam logic [14:0] IDLE = 15'h000a;
  localparam logic [7:0] RST_TAB [0:6] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  localparam logic [15:0] EXP [1:14] = '{16'h4000, 16'h1000, 16'h0020, 16'h0040, 16'h0080,
    16'h0800, 16'h0010, 16'h0200, 16'h0400, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0100};

  logic sys_clk;
  logic rstn;
  host_req_t host_req;
  logic [DATA_W-1:0] host_rdata;
  monitor_events_t ev;
  logic smi_n;
  logic alt_irq;
  logic reset_out_n;
  logic bp_out;
  logic bp_oe_n;
  logic bp_pin;
  logic [7:0] lo;
  logic [7:0] hi;
  int mismatches = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  // Open-drain pin with a pull-up
  assign bp_pin = bp_oe_n ? 1'b1 : bp_out;

  monitor_interrupt_control #(.RESET_PULSE_CYCLES(PULSE)) u_monitor_interrupt_control (
    .sys_clk(sys_clk), .rstn(rstn), .host_req(host_req), .host_rdata(host_rdata),
    .events(ev), .system_mgmt_irq_n(smi_n), .alt_irq(alt_irq), .reset_out_n(reset_out_n),
    .power_bypass_in(bp_pin), .power_bypass_out(bp_out), .power_bypass_oe_n(bp_oe_n));

  host_port_model u_host_port_model (
    .sys_clk(sys_clk), .host_rdata(host_rdata), .host_req(host_req));

  task automatic close_out();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
    logic [DATA_W-1:0] d;
    u_host_port_model.set_ptr(a);
    u_host_port_model.get(d);
    check({8'h00, d}, {8'h00, want});
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    u_host_port_model.wr_reg(a, d);
    repeat (3) @(negedge sys_clk);
  endtask

  // One-cycle flip of event bit k away from its idle level
  task automatic pulse(input int k);
    @(negedge sys_clk);
    ev = monitor_events_t'(IDLE ^ (15'h0001 << k));
    @(negedge sys_clk);
    ev = monitor_events_t'(IDLE);
    repeat (3) @(negedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end

  initial begin
    rstn = 1'b0;
    ev = monitor_events_t'(IDLE);
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    check({12'h000, smi_n, alt_irq, reset_out_n, bp_oe_n}, 16'h000f);
    for (n = 0; n < 7; n++) chk_rd(ADDR_CFG + ADDR_W'(n), RST_TAB[n]);
    chk_rd(7'h4f, 8'h00);
    wr(ADDR_STAT_LO, 8'hff);
    chk_rd(ADDR_STAT_LO, 8'h00);
    // Hold-off from power-on: events are not latched
    pulse(7);
    pulse(1);
    chk_rd(ADDR_STAT_LO, 8'h00);
    chk_rd(ADDR_STAT_HI, 8'h00);
    u_host_port_model.start_monitor(8'h06);
    chk_rd(ADDR_CFG, 8'h07);
    for (n = 1; n < 15; n++) begin
      pulse(n);
      check({14'h0, smi_n, alt_irq}, {15'h0, n == 1});
      u_host_port_model.set_ptr(ADDR_STAT_LO);
      u_host_port_model.get(lo);
      u_host_port_model.get(hi);
      check({hi, lo}, EXP[n]);
      repeat (3) @(negedge sys_clk);
      check({14'h0, smi_n, alt_irq}, 16'h0003);
    end
    wr(ADDR_SMASK_LO, 8'h10);
    wr(ADDR_CFG, 8'h27);
    check({15'h0, alt_irq}, 16'h0000);
    pulse(7);
    check({14'h0, smi_n, alt_irq}, 16'h0003);
    wr(ADDR_SMASK_LO, 8'h00);
    wr(ADDR_CFG, 8'h26);
    check({14'h0, smi_n, alt_irq}, 16'h0001);
    wr(ADDR_CFG, 8'h2e);
    check({14'h0, smi_n, alt_irq}, 16'h0002);
    chk_rd(ADDR_STAT_LO, 8'h10);
    wr(ADDR_CFG, 8'h27);
    check({14'h0, smi_n, alt_irq}, 16'h0001);
    chk_rd(ADDR_STAT_LO, 8'h10);
    wr(ADDR_CFG, 8'h01);
    pulse(7);
    check({14'h0, smi_n, alt_irq}, 16'h0003);
    chk_rd(ADDR_STAT_LO, 8'h10);
    wr(ADDR_CFG, 8'h06);
    pulse(7);
    chk_rd(ADDR_STAT_LO, 8'h00);
    wr(ADDR_CFG, 8'h07);
    repeat (31) pulse(0);
    chk_rd(ADDR_STAT_HI, 8'h00);
    pulse(0);
    check({15'h0, smi_n}, 16'h0000);
    chk_rd(ADDR_STAT_HI, 8'h20);
    // Every flag masked for the management output; chained is masked for NMI/IRQ from reset
    wr(ADDR_SMASK_LO, 8'hff);
    wr(ADDR_SMASK_HI, 8'h7f);
    pulse(1);
    check({14'h0, smi_n, alt_irq}, 16'h0003);
    chk_rd(ADDR_STAT_HI, 8'h40);
    wr(ADDR_CFG, 8'h40);
    check({14'h0, bp_oe_n, bp_out}, 16'h0000);
    wr(ADDR_SMASK_LO, 8'h55);
    u_host_port_model.wr_reg(ADDR_NMASK_LO, 8'h5a);
    u_host_port_model.access(1'b0, 1'b0, 8'h00);
    check({8'h00, host_rdata}, {9'h000, ADDR_NMASK_HI});
    chk_rd(ADDR_NMASK_LO, 8'h5a);
    wr(ADDR_CFG, 8'hc0);
    chk_rd(ADDR_CFG, 8'h08);
    chk_rd(ADDR_SMASK_LO, 8'h00);
    chk_rd(ADDR_NMASK_LO, 8'h00);
    check({15'h0, bp_oe_n}, 16'h0001);
    wr(ADDR_CFG, 8'h10);
    check({15'h0, reset_out_n}, 16'h0001);
    chk_rd(ADDR_CFG, 8'h10);
    u_host_port_model.wr_reg(ADDR_SMASK_HI, 8'h80);
    lo = 8'h00;
    repeat (40) begin
      @(negedge sys_clk);
      if (reset_out_n === 1'b0) lo++;
    end
    check({8'h00, lo}, 16'(PULSE));
    chk_rd(ADDR_CFG, 8'h00);
    close_out();
  end
endmodule
